// [tbase_irq.sv]
// Two periodic time base generators with request flags, servicing and wake-up.
// Assumes AHB-Lite register access; pin inputs synchronous to clk.

module tbase_irq
    import tbase_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Slow subsidiary clock, synchronised and counted on its rising edge
    input  wire logic        sub_clk,
    // Core side
    input  wire logic        stack_full,
    input  wire logic        core_asleep,
    output logic             vec_call,
    output logic             vec_sel,
    output logic             push_pc,
    output logic             wake_up,
    output logic             irq
);

    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    ahb_req_t   req;
    logic       wr_pend_q;
    logic       rd_pend_q;
    logic [7:0] addr_q;
    wire        xfer_ok;

    assign req     = '{hsel, haddr, htrans, hwrite, hsize, hready};
    assign xfer_ok = req.hsel && req.hready &&
                     (req.htrans == HTRANS_NONSEQ || req.htrans == HTRANS_SEQ);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= xfer_ok && req.hwrite;
            rd_pend_q <= xfer_ok && !req.hwrite;
        end
    end

    // Address held for the whole data phase, wait state included
    always_ff @(posedge clk) begin
        if (rst)
            addr_q <= 8'h00;
        else if (xfer_ok)
            addr_q <= req.haddr[7:0];
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire wr_psc   = wr_pend_q && (addr_q == ADDR_PSC_SEL);
    wire wr_tb0   = wr_pend_q && (addr_q == ADDR_TB0_CTRL);
    wire wr_tb1   = wr_pend_q && (addr_q == ADDR_TB1_CTRL);
    wire wr_ictl  = wr_pend_q && (addr_q == ADDR_INT_CTRL);
    wire wr_flags = wr_pend_q && (addr_q == ADDR_FLAGS);
    wire wr_cmd   = wr_pend_q && (addr_q == ADDR_CPU_CMD);
    wire wr_stat  = wr_pend_q && (addr_q == ADDR_STATUS);
    wire wr_mask  = wr_pend_q && (addr_q == ADDR_IRQ_MASK);

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [SRC_W-1:0] psc_src_q;
    tbase_ctrl_t      tb_ctrl_q [NUM_TB];
    logic             gie_q;
    logic [NUM_TB-1:0] local_en_q;
    logic [NUM_TB-1:0] irq_mask_q;

    wire [NUM_TB-1:0] wr_tb = {wr_tb1, wr_tb0};

    always_ff @(posedge clk) begin
        if (rst)
            psc_src_q <= '0;
        else if (wr_psc)
            psc_src_q <= hwdata[SRC_W-1:0];
    end

    always_ff @(posedge clk) begin
        if (rst)
            local_en_q <= '0;
        else if (wr_ictl)
            local_en_q <= hwdata[EN1_BIT:EN0_BIT];
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq_mask_q <= '0;
        else if (wr_mask)
            irq_mask_q <= hwdata[NUM_TB-1:0];
    end

    // ----------------------------------------
    // Prescaler clock enable
    // ----------------------------------------
    logic [DIV_W-1:0] sys_div_q;
    logic             sub_s1_q;
    logic             sub_s2_q;
    logic             sub_s3_q;
    logic             psc_tick;

    always_ff @(posedge clk) begin
        if (rst)
            sys_div_q <= '0;
        else
            sys_div_q <= sys_div_q + 1'b1;
    end

    // ----------------------------------------
    // Slow clock edge
    // ----------------------------------------
    // Two stages against metastability, third for the edge
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            sub_s1_q <= sub_clk;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    wire div_tick = (sys_div_q == DIV_W'(SYS_DIV - 1));
    wire sub_tick = sub_s2_q && !sub_s3_q;

    assign psc_tick = (psc_src_q == SRC_SYS)     ? 1'b1 :
                      (psc_src_q == SRC_SYS_DIV) ? div_tick :
                                                   sub_tick;

    // ----------------------------------------
    // Dividers and request flags
    // ----------------------------------------
    logic [NUM_TB-1:0] overflow;
    logic [NUM_TB-1:0] flag_q;
    logic [NUM_TB-1:0] take;

    genvar g;
    generate
        for (g = 0; g < NUM_TB; g++) begin : g_tb
            logic [CNT_W-1:0] cnt_q;
            wire  [CNT_W-1:0] top = CNT_W'((32'd1 << (MIN_EXP + tb_ctrl_q[g].period)) - 1);
            assign overflow[g] = tb_ctrl_q[g].run && psc_tick && (cnt_q == top);

            // Run bit and period of this time base
            always_ff @(posedge clk) begin
                if (rst)
                    tb_ctrl_q[g] <= '0;
                else if (wr_tb[g])
                    tb_ctrl_q[g] <= '{hwdata[RUN_BIT], hwdata[PERIOD_W-1:0]};
            end

            always_ff @(posedge clk) begin
                if (rst || !tb_ctrl_q[g].run)
                    cnt_q <= '0;
                else if (overflow[g])
                    cnt_q <= '0;
                else if (psc_tick)
                    cnt_q <= cnt_q + 1'b1;
            end

            // Overflow wins over clear
            always_ff @(posedge clk) begin
                if (rst)
                    flag_q[g] <= 1'b0;
                else if (overflow[g])
                    flag_q[g] <= 1'b1;
                else if (wr_flags)
                    flag_q[g] <= hwdata[g];
                else if (take[g])
                    flag_q[g] <= 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------
    // Servicing
    // ----------------------------------------
    // No new take in the cycle that signals a call
    wire [NUM_TB-1:0] ready_req = flag_q & local_en_q &
                                  {NUM_TB{gie_q && !stack_full && !vec_call}};
    // Time base 0 wins a tie
    assign take[0] = ready_req[0];
    assign take[1] = ready_req[1] && !ready_req[0];
    wire any_take = |take;

    wire cmd_return_from_interrupt_instr = wr_cmd && hwdata[CMD_RETURN_FROM_INTERRUPT_INSTR_BIT];
    wire cmd_ret  = wr_cmd && hwdata[CMD_RET_BIT];

    always_ff @(posedge clk) begin
        if (rst)
            gie_q <= 1'b0;
        else if (any_take)
            gie_q <= 1'b0;
        else if (cmd_return_from_interrupt_instr)
            gie_q <= 1'b1;
        // Plain return leaves the enable as it is
        else if (cmd_ret)
            gie_q <= gie_q;
        else if (wr_ictl)
            gie_q <= hwdata[GIE_BIT];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vec_call <= 1'b0;
            vec_sel  <= 1'b0;
            push_pc  <= 1'b0;
        end else begin
            vec_call <= any_take;
            vec_sel  <= take[1];
            push_pc  <= any_take;
        end
    end

    // ----------------------------------------
    // Wake-up and interrupt status
    // ----------------------------------------
    logic [NUM_TB-1:0] flag_prev_q;
    logic [NUM_TB-1:0] status_q;
    wire  [NUM_TB-1:0] rise = flag_q & ~flag_prev_q;

    wire  [NUM_TB-1:0] stat_clr = wr_stat ? hwdata[NUM_TB-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_prev_q <= '0;
            wake_up     <= 1'b0;
        end else begin
            flag_prev_q <= flag_q;
            wake_up     <= core_asleep && (|rise);
        end
    end

    // A rising edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst)
            status_q <= '0;
        else
            status_q <= rise | (status_q & ~stat_clr);
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status_q & irq_mask_q);
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rd_psc;
    logic [31:0] rd_tb0;
    logic [31:0] rd_tb1;
    logic [31:0] rd_ictl;
    logic [31:0] rd_flags;
    logic [31:0] rd_stat;
    logic [31:0] rd_mask;
    logic [31:0] rd_mux;

    // Unused upper bits read as zero
    assign rd_psc   = {{(32-SRC_W){1'b0}}, psc_src_q};
    assign rd_tb0   = {24'h00_0000, tb_ctrl_q[0].run, 4'h0, tb_ctrl_q[0].period};
    assign rd_tb1   = {24'h00_0000, tb_ctrl_q[1].run, 4'h0, tb_ctrl_q[1].period};
    assign rd_ictl  = {27'h000_0000, core_asleep, stack_full, local_en_q, gie_q};
    assign rd_flags = {{(32-NUM_TB){1'b0}}, flag_q};
    assign rd_stat  = {{(32-NUM_TB){1'b0}}, status_q};
    assign rd_mask  = {{(32-NUM_TB){1'b0}}, irq_mask_q};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_q == ADDR_PSC_SEL)
            rd_mux = rd_psc;
        else if (addr_q == ADDR_TB0_CTRL)
            rd_mux = rd_tb0;
        else if (addr_q == ADDR_TB1_CTRL)
            rd_mux = rd_tb1;
        else if (addr_q == ADDR_INT_CTRL)
            rd_mux = rd_ictl;
        else if (addr_q == ADDR_FLAGS)
            rd_mux = rd_flags;
        else if (addr_q == ADDR_STATUS)
            rd_mux = rd_stat;
        else if (addr_q == ADDR_IRQ_MASK)
            rd_mux = rd_mask;
    end

    // ----------------------------------------
    // Bus response
    // ----------------------------------------
    // A read costs one wait state so that hrdata comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(xfer_ok && !req.hwrite);
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (rd_pend_q)
            hrdata <= rd_mux;
    end

endmodule

// [tbase_pkg.sv]
// Shared constants and types for the periodic time base block.
// Assumes a single 40 MHz system clock and an AHB-Lite register bus.
package tbase_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_PSC_SEL  = 8'h00;
    localparam logic [7:0] ADDR_TB0_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TB1_CTRL = 8'h08;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS    = 8'h10;
    localparam logic [7:0] ADDR_CPU_CMD  = 8'h14;
    localparam logic [7:0] ADDR_STATUS   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int RUN_BIT       = 7;
    localparam int PERIOD_W      = 3;
    localparam int SRC_W         = 2;
    localparam int GIE_BIT       = 0;
    localparam int EN0_BIT       = 1;
    localparam int EN1_BIT       = 2;
    localparam int STACK_FULL_BIT = 3;
    localparam int SLEEP_BIT     = 4;
    localparam int CMD_RETURN_FROM_INTERRUPT_INSTR_BIT  = 0;
    localparam int CMD_RET_BIT   = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Prescaler sources and divider
    localparam logic [1:0] SRC_SYS     = 2'h0;
    localparam logic [1:0] SRC_SYS_DIV = 2'h1;
    localparam int         SYS_DIV     = 4;
    localparam int         DIV_W       = 2;
    localparam int         CNT_W       = 15;
    localparam int         MIN_EXP     = 8;
    localparam int         NUM_TB      = 2;

    // Time base control register fields
    typedef struct packed {
        logic                run;
        logic [PERIOD_W-1:0] period;
    } tbase_ctrl_t;

    // AHB-Lite slave request
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } ahb_req_t;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    typedef enum logic [1:0] {
        CPU_RUN,
        CPU_VEC0,
        CPU_VEC1
    } vec_state_t;

endpackage

// [tbase_irq_properties.sv]
// Concurrent checks on the ports of tbase_irq.
// Assumes one clock domain with synchronous active-high reset.
module tbase_irq_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic stack_full,
    input wire logic core_asleep,
    input wire logic vec_call,
    input wire logic push_pc,
    input wire logic wake_up,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Bus and servicing
    // ----------------------------------------
    a_ready_wait: assert property (!hreadyout |=> hreadyout) else $error("wait state longer than one cycle");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_push_only: assert property (push_pc == vec_call) else $error("push_pc apart from vec_call");
    a_call_gap: assert property (vec_call |=> !vec_call [*2]) else $error("call repeated");
    a_full_blocks: assert property (stack_full |=> !vec_call) else $error("call with stack full");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !vec_call && !wake_up && !irq)
        else $error("output active after reset");

    // ----------------------------------------
    // Wake-up
    // ----------------------------------------
    a_wake_asleep: assert property (wake_up |-> $past(core_asleep) || $past(core_asleep, 2))
        else $error("wake while awake");
    a_wake_pulse: assert property (wake_up |=> !wake_up) else $error("wake longer than one cycle");
endmodule

bind tbase_irq tbase_irq_properties u_props (
    .clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .stack_full(stack_full),
    .core_asleep(core_asleep), .vec_call(vec_call), .push_pc(push_pc), .wake_up(wake_up), .irq(irq)
);

// [tbase_irq_tb.sv]
// Self-checking bench for tbase_irq.
// Assumes the checker is bound in; drives AHB-Lite with hready fed back.
module tbase_irq_tb
    import tbase_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hsel, hwrite, sub_clk, stack_full, core_asleep, scall;
    logic        hreadyout, hresp, vec_call, vec_sel, push_pc, wake_up, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    int          fails, n_compared, ncall, nwake, cyc, tcall, t1, n0;
    typedef struct packed {logic [7:0] a, w, e;} reg_row_t;
    typedef struct packed {logic [1:0] s; logic t; logic [2:0] c; int n;} per_row_t;
    reg_row_t regs[4] = '{'{ADDR_PSC_SEL, 8'hFF, 8'h03}, '{ADDR_TB0_CTRL, 8'hFF, 8'h87},
                          '{ADDR_TB1_CTRL, 8'hFF, 8'h87}, '{8'h20, 8'hFF, 8'h00}};
    per_row_t per[5] = '{'{2'h0, 1'b0, 3'h0, 256}, '{2'h0, 1'b1, 3'h1, 512}, '{2'h1, 1'b1, 3'h0, 1024},
                         '{2'h2, 1'b0, 3'h0, 2048}, '{2'h3, 1'b1, 3'h0, 2048}};

    tbase_irq u_dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sub_clk(sub_clk), .stack_full(stack_full), .core_asleep(core_asleep),
        .vec_call(vec_call), .vec_sel(vec_sel), .push_pc(push_pc), .wake_up(wake_up), .irq(irq)
    );

    // ----------------------------------------
    // Clocks and event monitor
    // ----------------------------------------
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 0) sub_clk <= ~sub_clk;
        if (vec_call === 1'b1) begin
            ncall <= ncall + 1;
            tcall <= cyc;
            scall <= vec_sel;
        end
        if (wake_up === 1'b1) nwake <= nwake + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel <= 1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task wait_call(input int lim);
        n0 = ncall;
        repeat (lim) begin
            @(posedge clk);
            if (ncall != n0) break;
        end
        if (ncall == n0) begin
            fails++;
            $display("Error t=%0t call count got %h exp %h", $time, ncall, n0 + 1);
        end
    endtask
    task conclude;
        $display("Compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; sub_clk = 0;
        stack_full = 0; core_asleep = 0; fails = 0; n_compared = 0; ncall = 0; nwake = 0; cyc = 0;
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        foreach (regs[i]) begin
            bus(regs[i].a, 0, 8'h00);
            chk(r, 32'h0000_0000);
            bus(regs[i].a, 1, regs[i].w);
            bus(regs[i].a, 0, 8'h00);
            chk(r, {24'h00_0000, regs[i].e});
        end
        foreach (per[i]) begin
            bus(ADDR_TB0_CTRL, 1, 8'h00);
            bus(ADDR_TB1_CTRL, 1, 8'h00);
            bus(ADDR_INT_CTRL, 1, 8'h00);
            bus(ADDR_PSC_SEL, 1, {6'h00, per[i].s});
            bus(per[i].t ? ADDR_TB1_CTRL : ADDR_TB0_CTRL, 1, {5'h10, per[i].c});
            bus(ADDR_INT_CTRL, 1, per[i].t ? 8'h05 : 8'h03);
            wait_call(5000);
            t1 = tcall;
            bus(ADDR_CPU_CMD, 1, 8'h01);
            wait_call(5000);
            chk(32'(tcall - t1), 32'(per[i].n));
            chk(32'(scall), 32'(per[i].t));
        end
        // Both pending while the stack is full
        stack_full <= 1;
        bus(ADDR_PSC_SEL, 1, 8'h00);
        bus(ADDR_TB0_CTRL, 1, 8'h80);
        bus(ADDR_TB1_CTRL, 1, 8'h80);
        bus(ADDR_INT_CTRL, 1, 8'h07);
        n0 = ncall;
        repeat (600) @(posedge clk);
        bus(ADDR_TB0_CTRL, 1, 8'h00);
        bus(ADDR_TB1_CTRL, 1, 8'h00);
        chk(32'(ncall - n0), 32'h0000_0000);
        stack_full <= 0;
        wait_call(20);
        chk(32'(scall), 32'h0000_0000);
        bus(ADDR_CPU_CMD, 1, 8'h02);
        n0 = ncall;
        repeat (50) @(posedge clk);
        bus(ADDR_INT_CTRL, 0, 8'h00);
        chk({31'h0, r[GIE_BIT]} | 32'(ncall - n0), 32'h0000_0000);
        bus(ADDR_CPU_CMD, 1, 8'h01);
        wait_call(20);
        chk(32'(scall), 32'h0000_0001);
        bus(ADDR_FLAGS, 0, 8'h00);
        chk(r & 32'h0000_0003, 32'h0000_0000);
        // Wake on a rising flag, none from a preset flag
        core_asleep <= 1;
        n0 = nwake;
        bus(ADDR_TB0_CTRL, 1, 8'h80);
        repeat (300) @(posedge clk);
        chk(32'(nwake - n0), 32'h0000_0001);
        bus(ADDR_FLAGS, 0, 8'h00);
        chk(r & 32'h0000_0001, 32'h0000_0001);
        core_asleep <= 0;
        bus(ADDR_FLAGS, 1, 8'h03);
        @(posedge clk);
        core_asleep <= 1;
        bus(ADDR_TB1_CTRL, 1, 8'h80);
        repeat (300) @(posedge clk);
        chk(32'(nwake - n0), 32'h0000_0001);
        // Status, mask and interrupt line
        bus(ADDR_TB0_CTRL, 1, 8'h00);
        bus(ADDR_TB1_CTRL, 1, 8'h00);
        bus(ADDR_IRQ_MASK, 1, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(ADDR_IRQ_MASK, 1, 8'h03);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        bus(ADDR_STATUS, 1, 8'h03);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        conclude;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        conclude;
    end
endmodule
